// ==== inc/csfr_pkg.sv ====
// constants for the serial word offset, overflow, filter and driver register bank
package csfr_pkg;
    localparam logic [7:0] CSFR_OFS_WORD_OFFSET = 8'h0A;
    localparam logic [7:0] CSFR_OFS_OVF_PLL     = 8'h0B;
    localparam logic [7:0] CSFR_OFS_FILTER      = 8'h0C;
    localparam logic [7:0] CSFR_OFS_RSVD13      = 8'h0D;
    localparam logic [7:0] CSFR_OFS_DRIVER      = 8'h0E;

    localparam logic [7:0] CSFR_RST_WORD_OFFSET = 8'h00;
    localparam logic [3:0] CSFR_RST_PLL_DIV     = 4'h1;
    localparam logic [7:0] CSFR_RST_FILTER      = 8'h00;
    localparam logic [7:0] CSFR_RST_RSVD13      = 8'h00;
    localparam logic [7:0] CSFR_RST_DRIVER      = 8'h00;

    // overflow flag positions in register 11
    localparam int CSFR_OVF_LADC = 7;
    localparam int CSFR_OVF_RADC = 6;
    localparam int CSFR_OVF_LDAC = 5;
    localparam int CSFR_OVF_RDAC = 4;
    // filter control fields in register 12
    localparam int CSFR_HPF_L_LSB = 6;
    localparam int CSFR_HPF_R_LSB = 4;
    localparam int CSFR_FX_L      = 3;
    localparam int CSFR_DEEMP_L   = 2;
    localparam int CSFR_FX_R      = 1;
    localparam int CSFR_DEEMP_R   = 0;
    // driver register fields in register 14
    localparam int CSFR_DRV_ACCPL   = 7;
    localparam int CSFR_DRV_FULLDIF = 6;
    localparam int CSFR_DRV_HEADSET = 4;
    localparam int CSFR_DRV_PSEUDO  = 3;
    localparam logic [7:0] CSFR_DRV_WR_MASK = 8'hC8;

    localparam logic [4:0] CSFR_PLL_DIV_ZERO_CODE = 5'h10;
    localparam logic [8:0] CSFR_FRAME_256_CLKS    = 9'h100;

    typedef enum logic [1:0]
    {
        CSFR_FMT_I2S = 2'b00,
        CSFR_FMT_DSP = 2'b01,
        CSFR_FMT_RIGHT_JUSTIFIED = 2'b10,
        CSFR_FMT_LEFT_JUSTIFIED  = 2'b11
    } csfr_fmt_t;
endpackage

// ==== src/csfr_regs.sv ====
// register bank 10 to 14: word offset, overflow flags, pll divider, filters, driver config
// Contract
// - 8-bit word offset, code equals bit clocks
// - dsp mode counts offset from word clock rise
// - four sticky overflow flags in bits 7..4
// - reading flags returns then clears them, except flags whose synchronised overflow input is still high
// - pll divider code 0 means 16, reset 1
// - 2-bit adc high-pass select per channel
// - dac effects enables at bits 3 and 1
// - dac de-emphasis enables at bits 2 and 0
// - bit 7 selects ac-coupled or capless drivers
// - bit 4 read-only headset detect flag
// - 256-clock mode with bit clock as output gives 256 bit clocks per frame, else 0
// - mode codes: i2s, dsp, right-, left-justified
`timescale 1ns/1ps
module csfr_regs
(
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    input  wire logic [7:0]            reg_addr,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [7:0]            reg_wdata,
    output logic      [7:0]            reg_rdata,
    input  wire logic [1:0]            transfer_mode,
    input  wire logic                  clock_256_mode,
    input  wire logic                  bit_clock_is_output,
    input  wire logic                  ovf_left_adc,
    input  wire logic                  ovf_right_adc,
    input  wire logic                  ovf_left_dac,
    input  wire logic                  ovf_right_dac,
    input  wire logic                  headset_detect,
    output logic      [7:0]            word_offset,
    output logic                       offset_from_wclk_rise,
    output logic      [8:0]            frame_bit_clocks,
    output csfr_pkg::csfr_fmt_t        serial_format,
    output logic      [4:0]            pll_divider,
    output logic      [1:0]            hpf_left_sel,
    output logic      [1:0]            hpf_right_sel,
    output logic                       hpf_left_en,
    output logic                       hpf_right_en,
    output logic                       fx_left_en,
    output logic                       fx_right_en,
    output logic                       deemph_left_en,
    output logic                       deemph_right_en,
    output logic                       driver_ac_coupled,
    output logic                       driver_fully_diff,
    output logic                       driver_pseudo_diff,
    output logic                       headset_flag
);
    import csfr_pkg::*;

    logic       rst_s1_q;
    logic       rst_s2_q;
    logic       rst_n;
    logic       hs_s1_q;
    logic       hs_s2_q;
    logic [3:0] ovf_s1_q;
    logic [3:0] ovf_s2_q;
    logic [3:0] ovf_flag;
    logic       rd_ovf;

    logic [7:0] offset_q;
    logic [7:0] offset_d;
    logic [3:0] pll_q;
    logic [3:0] pll_d;
    logic [7:0] filt_q;
    logic [7:0] filt_d;
    logic [7:0] rsvd_q;
    logic [7:0] rsvd_d;
    logic [7:0] drv_q;
    logic [7:0] drv_d;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;

    // reset release synchroniser
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // pin synchronisers for overflow and headset inputs
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ovf_s1_q <= 4'h0;
            ovf_s2_q <= 4'h0;
            hs_s1_q  <= 1'b0;
            hs_s2_q  <= 1'b0;
        end
        else
        begin
            ovf_s1_q <= {ovf_left_adc, ovf_right_adc, ovf_left_dac, ovf_right_dac};
            ovf_s2_q <= ovf_s1_q;
            hs_s1_q  <= headset_detect;
            hs_s2_q  <= hs_s1_q;
        end
    end

    assign rd_ovf = reg_rd && (reg_addr == CSFR_OFS_OVF_PLL);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_ovf
            csfr_sticky u_flag
            (
                .clock  (clock),
                .rst_n  (rst_n),
                .set_in (ovf_s2_q[gi]),
                .clr_in (rd_ovf),
                .flag_q (ovf_flag[gi])
            );
        end
    endgenerate

    always_comb
    begin
        offset_d = offset_q;
        pll_d    = pll_q;
        filt_d   = filt_q;
        rsvd_d   = rsvd_q;
        drv_d    = drv_q;
        if (reg_wr)
        begin
            unique case (reg_addr)
                CSFR_OFS_WORD_OFFSET: offset_d = reg_wdata;
                CSFR_OFS_OVF_PLL:     pll_d    = reg_wdata[3:0];
                CSFR_OFS_FILTER:      filt_d   = reg_wdata;
                CSFR_OFS_RSVD13:      rsvd_d   = reg_wdata;
                CSFR_OFS_DRIVER:      drv_d    = reg_wdata & CSFR_DRV_WR_MASK;
                default:              offset_d = offset_q;
            endcase
        end
        rdata_d = rdata_q;
        if (reg_rd)
        begin
            unique case (reg_addr)
                CSFR_OFS_WORD_OFFSET: rdata_d = offset_q;
                CSFR_OFS_OVF_PLL:     rdata_d = {ovf_flag, pll_q};
                CSFR_OFS_FILTER:      rdata_d = filt_q;
                CSFR_OFS_RSVD13:      rdata_d = rsvd_q;
                CSFR_OFS_DRIVER:      rdata_d = {drv_q[7:5], hs_s2_q, drv_q[3:0]};
                default:              rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            offset_q <= CSFR_RST_WORD_OFFSET;
            pll_q    <= CSFR_RST_PLL_DIV;
            filt_q   <= CSFR_RST_FILTER;
            rsvd_q   <= CSFR_RST_RSVD13;
            drv_q    <= CSFR_RST_DRIVER;
            rdata_q  <= 8'h00;
        end
        else
        begin
            offset_q <= offset_d;
            pll_q    <= pll_d;
            filt_q   <= filt_d;
            rsvd_q   <= rsvd_d;
            drv_q    <= drv_d;
            rdata_q  <= rdata_d;
        end
    end

    assign reg_rdata             = rdata_q;
    assign word_offset           = offset_q;
    assign serial_format         = csfr_fmt_t'(transfer_mode);
    assign offset_from_wclk_rise = (serial_format == CSFR_FMT_DSP);
    assign frame_bit_clocks      = (clock_256_mode && bit_clock_is_output) ?
                                   CSFR_FRAME_256_CLKS : 9'h000;
    assign pll_divider           = (pll_q == 4'h0) ? CSFR_PLL_DIV_ZERO_CODE : {1'b0, pll_q};
    assign hpf_left_sel          = filt_q[CSFR_HPF_L_LSB +: 2];
    assign hpf_right_sel         = filt_q[CSFR_HPF_R_LSB +: 2];
    assign hpf_left_en           = (hpf_left_sel != 2'b00);
    assign hpf_right_en          = (hpf_right_sel != 2'b00);
    assign fx_left_en            = filt_q[CSFR_FX_L];
    assign fx_right_en           = filt_q[CSFR_FX_R];
    assign deemph_left_en        = filt_q[CSFR_DEEMP_L];
    assign deemph_right_en       = filt_q[CSFR_DEEMP_R];
    assign driver_ac_coupled     = drv_q[CSFR_DRV_ACCPL];
    assign driver_fully_diff     = drv_q[CSFR_DRV_FULLDIF];
    assign driver_pseudo_diff    = drv_q[CSFR_DRV_PSEUDO];
    assign headset_flag          = hs_s2_q;
endmodule // csfr_regs

// ==== src/csfr_sticky.sv ====
// one sticky clear-on-read flag
`timescale 1ns/1ps
module csfr_sticky
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic set_in,
    input  wire logic clr_in,
    output logic      flag_q
);
    logic flag_d;

    always_comb
    begin
        flag_d = flag_q;
        if (clr_in)
        begin
            flag_d = 1'b0;
        end
        if (set_in)
        begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_q <= 1'b0;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end
endmodule // csfr_sticky

// ==== verification/csfr_host_model.sv ====
// host model driving the register access strobes
`timescale 1ns/1ps
module csfr_host_model
(
    input  wire logic       clock,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata
);
    initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 18'h0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = (a == 8'h0D) ? 8'h00 : d;
        if (a == 8'h0E && d[6] && d[3]) reg_wdata[3] = 1'b0;
        if (a == 8'h0E) reg_wdata = reg_wdata & 8'hC8;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_wdata = ~reg_wdata;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        @(negedge clock);
        d = reg_rdata;
    endtask
endmodule // csfr_host_model

// ==== verification/csfr_regs_asserts.sv ====
// assertion checker for the codec register bank
`timescale 1ns/1ps
module csfr_regs_asserts
(
    input wire logic                 clock,
    input wire logic                 rst_b,
    input wire logic [7:0]           reg_addr,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [7:0]           reg_wdata,
    input wire logic [7:0]           reg_rdata,
    input wire logic [1:0]           transfer_mode,
    input wire logic                 clock_256_mode,
    input wire logic                 bit_clock_is_output,
    input wire logic [7:0]           word_offset,
    input wire logic                 offset_from_wclk_rise,
    input wire logic [8:0]           frame_bit_clocks,
    input wire csfr_pkg::csfr_fmt_t  serial_format,
    input wire logic [4:0]           pll_divider,
    input wire logic                 driver_ac_coupled,
    input wire logic                 driver_fully_diff,
    input wire logic                 driver_pseudo_diff,
    input wire logic                 headset_flag
);
    import csfr_pkg::*;
    logic [7:0] wd_q;
    logic       hs_q;
    always_ff @(posedge clock)
    begin
        wd_q <= reg_wdata;
        hs_q <= headset_flag;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_wr(a); reg_wr && reg_addr == a; endsequence
    sequence s_rd(a); reg_rd && reg_addr == a; endsequence
    property p_offset; s_wr(8'h0A) |=> word_offset == wd_q; endproperty
    a_offset: assert property (p_offset) else $error("word offset not stored");
    property p_dsp; offset_from_wclk_rise == (transfer_mode == 2'h1); endproperty
    a_dsp: assert property (p_dsp) else $error("offset edge select wrong");
    property p_fmt; serial_format == transfer_mode; endproperty
    a_fmt: assert property (p_fmt) else $error("format decode wrong");
    property p_frame;
        frame_bit_clocks == ((clock_256_mode && bit_clock_is_output) ? 9'h100 : 9'h000);
    endproperty
    a_frame: assert property (p_frame) else $error("frame clock count wrong");
    property p_pll;
        s_wr(8'h0B) |=> pll_divider == ((wd_q[3:0] == 4'h0) ? 5'h10 : {1'b0, wd_q[3:0]});
    endproperty
    a_pll: assert property (p_pll) else $error("divider decode wrong");
    property p_rd11; s_rd(8'h0B) |=> reg_rdata[3:0] == pll_divider[3:0]; endproperty
    a_rd11: assert property (p_rd11) else $error("divider readback wrong");
    property p_drv;
        s_wr(8'h0E) |=> {driver_ac_coupled, driver_fully_diff, driver_pseudo_diff} == {wd_q[7:6], wd_q[3]};
    endproperty
    a_drv: assert property (p_drv) else $error("driver bits not stored");
    property p_rd14;
        s_rd(8'h0E) |=>
            reg_rdata == {driver_ac_coupled, driver_fully_diff, 1'b0, hs_q, driver_pseudo_diff, 3'h0};
    endproperty
    a_rd14: assert property (p_rd14) else $error("driver register readback wrong");
endmodule // csfr_regs_asserts
bind csfr_regs csfr_regs_asserts u_csfr_regs_asserts (.*);

// ==== verification/tb_top.sv ====
// self-checking bench for the codec register bank
`timescale 1ns/1ps
module tb_top;
    import csfr_pkg::*;
    logic clock = 1'b0, rst_b = 1'b0, clock_256_mode = 1'b0, bit_clock_is_output = 1'b0, headset_detect = 1'b0;
    logic ovf_left_adc = 1'b0, ovf_right_adc = 1'b0, ovf_left_dac = 1'b0, ovf_right_dac = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, word_offset, rv;
    logic [1:0] transfer_mode = 2'h0, hpf_left_sel, hpf_right_sel;
    logic reg_wr, reg_rd, offset_from_wclk_rise, hpf_left_en, hpf_right_en, fx_left_en, fx_right_en;
    logic deemph_left_en, deemph_right_en, driver_ac_coupled, driver_fully_diff, driver_pseudo_diff, headset_flag;
    logic [8:0] frame_bit_clocks;
    logic [4:0] pll_divider;
    csfr_fmt_t serial_format;
    logic [8:0] hpf_seen;
    assign hpf_seen = {3'h0, hpf_left_sel, hpf_right_sel, hpf_left_en, hpf_right_en};
    int num_errors = 0, n_compared = 0;
    logic [7:0] wa[8] = '{8'h0A, 8'h0A, 8'h0B, 8'h0C, 8'h0C, 8'h0D, 8'h0E, 8'h0E};
    logic [7:0] wd[8] = '{8'h11, 8'hF2, 8'hF0, 8'h0A, 8'h05, 8'h00, 8'h40, 8'hB7};
    logic [7:0] we[8] = '{8'h11, 8'hF2, 8'h00, 8'h0A, 8'h05, 8'h00, 8'h40, 8'h80};
    csfr_regs u_csfr_regs (.*);
    csfr_host_model u_csfr_host_model (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
    always #12.5 clock = ~clock;
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        n_compared++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        u_csfr_host_model.rd(a, rv);
        chk("rdata", {1'b0, e}, {1'b0, rv});
    endtask
    task automatic ovf(input logic [3:0] v, input int n);
        {ovf_left_adc, ovf_right_adc, ovf_left_dac, ovf_right_dac} = v;
        repeat (n) @(negedge clock);
    endtask
    task automatic report_and_stop;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #50000;
        num_errors++;
        report_and_stop();
    end
    initial
    begin
        repeat (8) @(negedge clock);
        rst_b = 1'b1;
        repeat (4) @(negedge clock);
        for (int i = 0; i < 5; i++) rchk(8'h0A + 8'(i), (i == 1) ? 8'h01 : 8'h00);
        chk("pll", 9'h001, {4'h0, pll_divider});
        for (int m = 0; m < 4; m++)
        begin
            transfer_mode = m[1:0];
            {clock_256_mode, bit_clock_is_output} = m[1:0];
            @(negedge clock);
            chk("mode", {6'h0, m[1:0], m == 1}, {6'h0, serial_format, offset_from_wclk_rise});
            chk("frame", (m == 3) ? 9'h100 : 9'h000, frame_bit_clocks);
        end
        for (int i = 0; i < 8; i++)
        begin
            u_csfr_host_model.wr(wa[i], wd[i]);
            rchk(wa[i], we[i]);
        end
        chk("pll", 9'h010, {4'h0, pll_divider});
        chk("offset", 9'h0F2, {1'b0, word_offset});
        chk("fx", 9'h005, {5'h0, fx_left_en, deemph_left_en, fx_right_en, deemph_right_en});
        chk("drv", 9'h004, {6'h0, driver_ac_coupled, driver_fully_diff, driver_pseudo_diff});
        for (int c = 0; c < 4; c++)
        begin
            u_csfr_host_model.wr(8'h0C, {c[1:0], c[1:0], 4'h0});
            chk("hpf", {3'h0, c[1:0], c[1:0], c != 0, c != 0}, hpf_seen);
        end
        ovf(4'hF, 1);
        ovf(4'h0, 3);
        rchk(8'h0B, 8'hF0);
        rchk(8'h0B, 8'h00);
        ovf(4'h8, 3);
        rchk(8'h0B, 8'h80);
        rchk(8'h0B, 8'h80);
        ovf(4'h0, 3);
        rchk(8'h0B, 8'h80);
        rchk(8'h0B, 8'h00);
        headset_detect = 1'b1;
        repeat (4) @(negedge clock);
        chk("headset", 9'h001, {8'h0, headset_flag});
        rchk(8'h0E, 8'h90);
        u_csfr_host_model.wr(8'h10, 8'h5A);
        rchk(8'h10, 8'h00);
        rchk(8'h0A, 8'hF2);
        report_and_stop();
    end
endmodule // tb_top
